/* File: dv/nsfp_host_rx.sv */
// Host-side serial receiver model that collects characters from the framer's line
`timescale 1ns/1ps
module nsfp_host_rx #(
  parameter int BIT_CYC = 8
) (
  // Clock and serial line
  input wire logic clk,
  input wire logic txd,
  // Received characters
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic frameErr
);
  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [7:0] shiftR; // Bits gathered so far

  // Quiet outputs until the first character lands
  initial begin
    rxByte = 8'h00;
    rxStrobe = 1'b0;
    frameErr = 1'b0;
  end

  // Always listening: the host cannot throttle the sender
  always begin
    @(negedge txd);
    // Sample mid-bit so the flop's edge timing never matters
    repeat (BIT_CYC / 2) @(posedge clk);
    if (txd === 1'b0) begin
      // Eight data bits, least significant first
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        shiftR[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clk);
      // One stop bit, no parity bit in between
      if (txd !== 1'b1) begin
        frameErr = 1'b1;
      end
      rxByte = shiftR;
      rxStrobe = 1'b1;
      @(posedge clk);
      rxStrobe = 1'b0;
    end
  end
endmodule // nsfp_host_rx

/* File: dv/test_nmea_sentence_framer_pps.sv */
// Self-checking bench of the sentence framer: framing, talkers, checksum and timing pulse
`timescale 1ns/1ps
module test_nmea_sentence_framer_pps;
  import nsfp_pkg::*;
  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  localparam int BIT_CYC = 8; // Short bit time keeps the run brief
  localparam int PPS_HIGH_CYC = 20; // Short pulse, same shape
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  nsfp_sent_t reqType = ST_GGA;
  nsfp_const_t reqConst = CN_GPS;
  logic reqReady;
  logic [7:0] dataByte = 8'h00;
  logic dataValid = 1'b0;
  logic dataNoChar = 1'b0;
  logic dataEndField = 1'b0;
  logic dataEndSentence = 1'b0;
  logic dataReady;
  logic txd;
  logic utcSecondTick = 1'b0;
  logic fix3d = 1'b0;
  logic [5:0] satsUsed = 6'h00;
  logic utcSecondPulseOut;
  logic [7:0] rxByte;
  logic rxStrobe;
  logic frameErr;
  logic [7:0] rxq[$]; // Characters seen by the host
  int errCount = 0;
  int testsRun = 0;
  string kinds[7] = '{"GGA", "GLL", "GSA", "GSV", "VTG", "RMC", "ZDA"}; // Type names in enum order
  string talks[4] = '{"GP", "GL", "GA", "GB"}; // Satellite-in-view talkers

  // 25 MHz clock
  always #20 clk = ~clk;

  nsfp_sentence_framer #(.BIT_CYC(BIT_CYC), .PPS_HIGH_CYC(PPS_HIGH_CYC)) i_nsfp_sentence_framer (
    .clk(clk), .srst(srst), .reqValid(reqValid), .reqType(reqType), .reqConst(reqConst),
    .reqReady(reqReady), .dataByte(dataByte), .dataValid(dataValid), .dataNoChar(dataNoChar),
    .dataEndField(dataEndField), .dataEndSentence(dataEndSentence), .dataReady(dataReady),
    .txd(txd), .utcSecondTick(utcSecondTick), .fix3d(fix3d), .satsUsed(satsUsed),
    .utcSecondPulseOut(utcSecondPulseOut));
  nsfp_host_rx #(.BIT_CYC(BIT_CYC)) i_nsfp_host_rx (
    .clk(clk), .txd(txd), .rxByte(rxByte), .rxStrobe(rxStrobe), .frameErr(frameErr));

  // Collect on the falling edge, where the strobe is settled
  always @(negedge clk) begin
    if (rxStrobe === 1'b1) begin
      rxq.push_back(rxByte);
    end
  end

  // ----------------------------------------------------------------
  // Compare and verdict
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Drivers: entered just after a rising edge, held until taken
  // ----------------------------------------------------------------
  task automatic put_req(input nsfp_sent_t t, input nsfp_const_t c);
    int n;
    reqType <= t;
    reqConst <= c;
    reqValid <= 1'b1;
    n = 0;
    // Ready only moves on rising edges, so its falling-edge value is what the edge sees
    @(negedge clk);
    while (reqReady !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    cmp_bit(reqReady, 1'b1);
    @(posedge clk);
    reqValid <= 1'b0;
  endtask
  // Valid stays up between beats so it is never written twice in one step
  task automatic put_beat(input logic [7:0] ch, input logic noCh, input logic endF, input logic endS);
    int n;
    dataByte <= ch;
    dataNoChar <= noCh;
    dataEndField <= endF;
    dataEndSentence <= endS;
    dataValid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (dataReady !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    cmp_bit(dataReady, 1'b1);
    @(posedge clk);
  endtask
  // Upper-case hex digit, worked out here rather than borrowed
  function automatic logic [7:0] hexc(input logic [3:0] n);
    if (n > 4'h9) return 8'h41 + {4'h0, n} - 8'h0A;
    return 8'h30 + {4'h0, n};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Sentence with a field, an empty field and a last field flagged both ways
  task automatic send_sentence(input nsfp_sent_t t, input nsfp_const_t c, input logic [7:0] ch);
    logic [7:0] exp[$];
    logic [7:0] sum;
    string tk;
    string kd;
    int n;
    kd = kinds[int'(t)];
    tk = (t == ST_GSV) ? talks[int'(c)] : "GN";
    exp = {8'h24, tk[0], tk[1], kd[0], kd[1], kd[2], 8'h2C, ch, 8'h2C, 8'h2C, ch + 8'h01};
    sum = 8'h00;
    for (int i = 1; i < exp.size(); i++) sum ^= exp[i];
    exp = {exp, 8'h2A, hexc(sum[7:4]), hexc(sum[3:0]), 8'h0D, 8'h0A};
    rxq.delete();
    put_req(t, c);
    put_beat(ch, 1'b0, 1'b1, 1'b0);
    // A beat with no character and no end flag must leave the stream alone
    put_beat(8'h00, 1'b1, 1'b0, 1'b0);
    put_beat(8'h00, 1'b1, 1'b1, 1'b0);
    // End of sentence must win over end of field: no comma before the star
    put_beat(ch + 8'h01, 1'b0, 1'b1, 1'b1);
    dataValid <= 1'b0;
    n = 0;
    while (rxq.size() < exp.size() && n < 4000) begin
      @(posedge clk);
      n++;
    end
    cmp_cnt(16'(rxq.size()), 16'(exp.size()));
    cmp_bit(reqReady, 1'b1);
    cmp_bit(dataReady, 1'b0);
    for (int i = 0; i < exp.size() && i < rxq.size(); i++) cmp_byte(rxq[i], exp[i]);
  endtask

  // One second boundary; optionally lose the fix a few cycles in
  task automatic pps_case(input logic fix, input logic [5:0] sats, input int dropAt, input logic [15:0] expHigh);
    int highs;
    fix3d <= fix;
    satsUsed <= sats;
    utcSecondTick <= 1'b1;
    @(negedge clk);
    cmp_bit(utcSecondPulseOut, 1'b0);
    highs = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i == 0) utcSecondTick <= 1'b0;
      if (i == dropAt) fix3d <= 1'b0;
      @(negedge clk);
      if (i == 0) cmp_bit(utcSecondPulseOut, expHigh != 16'h0000);
      if (utcSecondPulseOut === 1'b1) highs++;
    end
    cmp_cnt(16'(highs), expHigh);
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    @(posedge clk);
    @(negedge clk);
    cmp_bit(txd, 1'b1);
    cmp_bit(reqReady, 1'b0);
    cmp_bit(dataReady, 1'b0);
    cmp_bit(utcSecondPulseOut, 1'b0);
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 7; k++) send_sentence(nsfp_sent_t'(k), CN_GPS, 8'h41 + 8'(k));
    for (int k = 0; k < 4; k++) send_sentence(ST_GSV, nsfp_const_t'(k), 8'h30 + 8'(k));
    send_sentence(ST_GSA, CN_GLO, 8'h4D);
    send_sentence(ST_GSA, CN_GAL, 8'h4E);
    cmp_bit(frameErr, 1'b0);
    pps_case(1'b1, 6'h04, -1, 16'(PPS_HIGH_CYC));
    pps_case(1'b1, 6'h03, -1, 16'h0000);
    pps_case(1'b0, 6'h0C, -1, 16'h0000);
    pps_case(1'b1, 6'h08, 5, 16'h0006);
    print_verdict();
  end

  // Generous bound: the sentences take some twenty thousand cycles
  initial begin
    #(40 * 60000);
    errCount++;
    print_verdict();
  end
endmodule // test_nmea_sentence_framer_pps

/* File: rtl/nsfp_byte_if.sv */
// Byte handshake between the framer and its serial transmitter
`timescale 1ns/1ps
interface nsfp_byte_if;
  logic [7:0] data; // Character to send
  logic valid; // Character is waiting
  logic ready; // Transmitter takes it this cycle
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/nsfp_params.svh */
// Constants of the sentence framer and timing pulse: characters, rates and counts
`ifndef NSFP_PARAMS_SVH
`define NSFP_PARAMS_SVH

// ----------------------------------------------------------------
// Framing characters
// ----------------------------------------------------------------
`define NSFP_CH_DOLLAR 8'h24
`define NSFP_CH_COMMA 8'h2C
`define NSFP_CH_STAR 8'h2A
`define NSFP_CH_CR 8'h0D
`define NSFP_CH_LF 8'h0A

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NSFP_CLK_HZ 25000000
`define NSFP_BAUD 9600
// Clock cycles per bit rounded down to whole cycles: 2604 cycles per bit
`define NSFP_BIT_CYC ((`NSFP_CLK_HZ) / (`NSFP_BAUD))
// High time of the second pulse in milliseconds
`define NSFP_PPS_HIGH_MS 100
`define NSFP_PPS_HIGH_CYC ((`NSFP_CLK_HZ / 1000) * `NSFP_PPS_HIGH_MS)
// Least satellite count of a 3D fix that may drive the pulse
`define NSFP_MIN_SATS 6'h04

`endif

/* File: rtl/nsfp_pkg.sv */
// Types and character lookups of the sentence framer
package nsfp_pkg;

  // ----------------------------------------------------------------
  // Sentence types and constellations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_GGA, ST_GLL, ST_GSA, ST_GSV, ST_VTG, ST_RMC, ST_ZDA} nsfp_sent_t;
  typedef enum logic [1:0] {CN_GPS, CN_GLO, CN_GAL, CN_BDS} nsfp_const_t;

  // Address character idx (0..4) of a sentence
  function automatic logic [7:0] nsfp_addr_char(nsfp_sent_t t, nsfp_const_t c, logic [2:0] idx);
    logic [15:0] talk;
    logic [23:0] kind;
    talk = 16'h474E;
    kind = 24'h474741;
    // Satellite-in-view sentences carry their constellation's talker
    if (t == ST_GSV) begin
      unique case (c)
        CN_GPS: talk = 16'h4750;
        CN_GLO: talk = 16'h474C;
        CN_GAL: talk = 16'h4741;
        CN_BDS: talk = 16'h4742;
      endcase
    end
    // Only these seven types exist
    unique case (t)
      ST_GGA: kind = 24'h474741;
      ST_GLL: kind = 24'h474C4C;
      ST_GSA: kind = 24'h475341;
      ST_GSV: kind = 24'h475356;
      ST_VTG: kind = 24'h565447;
      ST_RMC: kind = 24'h524D43;
      ST_ZDA: kind = 24'h5A4441;
    endcase
    unique case (idx)
      3'h0: return talk[15:8];
      3'h1: return talk[7:0];
      3'h2: return kind[23:16];
      3'h3: return kind[15:8];
      default: return kind[7:0];
    endcase
  endfunction

  // Upper-case hexadecimal digit of a nibble
  function automatic logic [7:0] nsfp_hex_char(logic [3:0] n);
    return (n < 4'hA) ? ({4'h0, n} + 8'h30) : ({4'h0, n} + 8'h37);
  endfunction

endpackage

/* File: rtl/nsfp_sentence_framer.sv */
// Sentence framer with serial output and once-per-second timing pulse
// How it works
// - Dollar start, comma separators, asterisk before checksum
// - Two talker then three type characters
// - Carriage return, line feed close each sentence
// - Only GGA GLL GSA GSV VTG RMC ZDA
// - Combined-solution sentences use talker GN
// - Several GSA sentences when constellations mix
// - GSV talker per constellation: GP GL GA GB
// - 3D fix, four satellites: pulse each second
// - No fix: pulse output held low
// - 9600 baud, 8N1 after power-up
// - No flow control; host keeps line rate
`timescale 1ns/1ps
`include "nsfp_params.svh"
module nsfp_sentence_framer #(
  parameter int BIT_CYC = `NSFP_BIT_CYC,
  parameter int PPS_HIGH_CYC = `NSFP_PPS_HIGH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sentence request
  input wire logic reqValid,
  input wire nsfp_pkg::nsfp_sent_t reqType,
  input wire nsfp_pkg::nsfp_const_t reqConst,
  output logic reqReady,
  // Field data
  input wire logic [7:0] dataByte,
  input wire logic dataValid,
  input wire logic dataNoChar,
  input wire logic dataEndField,
  input wire logic dataEndSentence,
  output logic dataReady,
  // Serial line
  output logic txd,
  // Timing pulse
  input wire logic utcSecondTick,
  input wire logic fix3d,
  input wire logic [5:0] satsUsed,
  output logic utcSecondPulseOut
);
  import nsfp_pkg::*;
  localparam int PW = $clog2(PPS_HIGH_CYC + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {S_IDLE, S_DOLLAR, S_ADDR, S_COMMA, S_DATA, S_STAR, S_CKHI, S_CKLO, S_CR, S_LF} nsfp_st_t;
  nsfp_st_t stateR, stateNxt; // Position in the sentence
  logic [2:0] idxR, idxNxt; // Address character index
  logic [7:0] ckR, ckNxt; // Running checksum
  logic [7:0] chR, chNxt; // Character offered to the transmitter
  logic chValR, chValNxt; // Offered character not yet taken
  nsfp_sent_t typeR, typeNxt; // Latched sentence type
  nsfp_const_t constR, constNxt; // Latched constellation
  logic reqReadyR, reqReadyNxt; // Request slot open
  logic dataReadyR, dataReadyNxt; // Field data slot open
  logic ppsR, ppsNxt; // Pulse level
  logic [PW-1:0] ppsCntR, ppsCntNxt; // High cycles left
  logic fixOk; // Fix good enough to time the pulse
  logic txReady; // Transmitter takes the offered character
  nsfp_byte_if txIf ();

  assign txIf.data = chR;
  assign txIf.valid = chValR;
  assign txReady = txIf.ready;
  assign reqReady = reqReadyR;
  assign dataReady = dataReadyR;
  assign utcSecondPulseOut = ppsR;

  // ----------------------------------------------------------------
  // Serial transmitter
  // ----------------------------------------------------------------
  nsfp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(clk),
    .srst(srst),
    .bus(txIf),
    .txd(txd)
  );

  // ----------------------------------------------------------------
  // Sentence sequencing
  // ----------------------------------------------------------------
  // One character is held at a time; the framer waits on the transmitter,
  // which never waits on the host, so the line runs at full rate.
  always_comb begin
    stateNxt = stateR;
    idxNxt = idxR;
    ckNxt = ckR;
    chNxt = chR;
    typeNxt = typeR;
    constNxt = constR;
    // Taken characters free the slot; an untaken one stays put
    chValNxt = chValR && !txReady;
    unique case (stateR)
      S_IDLE: begin
        // Each request is one sentence; GSA may be asked for repeatedly
        if (reqValid && reqReadyR) begin
          typeNxt = reqType;
          constNxt = reqConst;
          stateNxt = S_DOLLAR;
        end
      end
      S_DOLLAR: begin
        // Start character, checksum cleared
        if (!chValR) begin
          chNxt = `NSFP_CH_DOLLAR;
          chValNxt = 1'b1;
          ckNxt = 8'h00;
          idxNxt = 3'h0;
          stateNxt = S_ADDR;
        end
      end
      S_ADDR: begin
        // Talker then sentence type
        if (!chValR) begin
          chNxt = nsfp_addr_char(typeR, constR, idxR);
          chValNxt = 1'b1;
          ckNxt = ckR ^ nsfp_addr_char(typeR, constR, idxR);
          idxNxt = idxR + 3'h1;
          if (idxR == 3'h4) begin
            stateNxt = S_COMMA;
          end
        end
      end
      S_COMMA: begin
        // Field separator, counted into the checksum
        if (!chValR) begin
          chNxt = `NSFP_CH_COMMA;
          chValNxt = 1'b1;
          ckNxt = ckR ^ `NSFP_CH_COMMA;
          stateNxt = S_DATA;
        end
      end
      S_DATA: begin
        if (dataValid && dataReadyR) begin
          // An empty beat sends no character; only its end flags act
          if (!dataNoChar) begin
            chNxt = dataByte;
            chValNxt = 1'b1;
            ckNxt = ckR ^ dataByte;
          end
          if (dataEndSentence) begin
            stateNxt = S_STAR;
          end else if (dataEndField) begin
            stateNxt = S_COMMA;
          end
        end
      end
      S_STAR: begin
        // Checksum delimiter, not counted
        if (!chValR) begin
          chNxt = `NSFP_CH_STAR;
          chValNxt = 1'b1;
          stateNxt = S_CKHI;
        end
      end
      S_CKHI: begin
        if (!chValR) begin
          chNxt = nsfp_hex_char(ckR[7:4]);
          chValNxt = 1'b1;
          stateNxt = S_CKLO;
        end
      end
      S_CKLO: begin
        if (!chValR) begin
          chNxt = nsfp_hex_char(ckR[3:0]);
          chValNxt = 1'b1;
          stateNxt = S_CR;
        end
      end
      S_CR: begin
        if (!chValR) begin
          chNxt = `NSFP_CH_CR;
          chValNxt = 1'b1;
          stateNxt = S_LF;
        end
      end
      S_LF: begin
        if (!chValR) begin
          chNxt = `NSFP_CH_LF;
          chValNxt = 1'b1;
          stateNxt = S_IDLE;
        end
      end
    endcase
    // Slots are offered only when the next cycle can take them
    reqReadyNxt = (stateNxt == S_IDLE);
    dataReadyNxt = (stateNxt == S_DATA) && !chValNxt;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      stateR <= S_IDLE;
      idxR <= 3'h0;
      ckR <= 8'h00;
      chR <= 8'h00;
      chValR <= 1'b0;
      typeR <= ST_GGA;
      constR <= CN_GPS;
      reqReadyR <= 1'b0;
      dataReadyR <= 1'b0;
    end else begin
      stateR <= stateNxt;
      idxR <= idxNxt;
      ckR <= ckNxt;
      chR <= chNxt;
      chValR <= chValNxt;
      typeR <= typeNxt;
      constR <= constNxt;
      reqReadyR <= reqReadyNxt;
      dataReadyR <= dataReadyNxt;
    end
  end
  // ----------------------------------------------------------------
  // Timing pulse
  // ----------------------------------------------------------------
  // Edge alignment is only as good as the tick input: one cycle late at most.
  assign fixOk = fix3d && (satsUsed >= `NSFP_MIN_SATS);

  always_comb begin
    ppsNxt = ppsR;
    ppsCntNxt = ppsCntR;
    if (!fixOk) begin
      // Losing the fix cuts a pulse short
      ppsNxt = 1'b0;
      ppsCntNxt = '0;
    end else if (utcSecondTick) begin
      // Rise on the second boundary
      ppsNxt = 1'b1;
      ppsCntNxt = PW'(PPS_HIGH_CYC - 1);
    end else if (ppsCntR != '0) begin
      ppsCntNxt = ppsCntR - PW'(1);
    end else begin
      ppsNxt = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ppsR <= 1'b0;
      ppsCntR <= '0;
    end else begin
      ppsR <= ppsNxt;
      ppsCntR <= ppsCntNxt;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_load(nsfp_st_t st);
    stateR == st && !chValR;
  endsequence
  property p_dollar;
    s_load(S_DOLLAR) |=> chValR && chR == `NSFP_CH_DOLLAR && stateR == S_ADDR && ckR == 8'h00;
  endproperty
  a_dollar: assert property (p_dollar) else $error("sentence did not open with dollar");
  // Second talker character tells GN apart from every per-constellation talker
  property p_gn_talker;
    s_load(S_ADDR) and (idxR == 3'h1) and (typeR != ST_GSV) |=> chR == 8'h4E;
  endproperty
  a_gn_talker: assert property (p_gn_talker) else $error("combined talker not GN");
  property p_addr_order;
    s_load(S_ADDR) |=> chR == nsfp_addr_char($past(typeR), $past(constR), $past(idxR)) && idxR == $past(idxR) + 3'h1;
  endproperty
  a_addr_order: assert property (p_addr_order) else $error("address character out of order");
  property p_gsv_talker;
    s_load(S_ADDR) and (idxR == 3'h1) and (typeR == ST_GSV) and (constR == CN_BDS) |=> chR == 8'h42;
  endproperty
  a_gsv_talker: assert property (p_gsv_talker) else $error("GSV talker wrong");
  property p_checksum;
    s_load(S_CKHI) |=> chR == nsfp_hex_char($past(ckR[7:4])) && stateR == S_CKLO;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum digit wrong");
  // Line feed must follow straight on the carriage return
  property p_tail;
    s_load(S_LF) |=> chR == `NSFP_CH_LF && stateR == S_IDLE && $past(chR) == `NSFP_CH_CR;
  endproperty
  a_tail: assert property (p_tail) else $error("sentence not closed by line feed");
  property p_hold;
    chValR && !txReady |=> chValR && $stable(chR);
  endproperty
  a_hold: assert property (p_hold) else $error("untaken character lost");
  property p_pps_rise;
    utcSecondTick && fixOk |=> ppsR;
  endproperty
  a_pps_rise: assert property (p_pps_rise) else $error("pulse missing on second tick");
  property p_pps_low;
    !fixOk |=> !ppsR && ppsCntR == '0;
  endproperty
  a_pps_low: assert property (p_pps_low) else $error("pulse high without fix");
endmodule // nsfp_sentence_framer

/* File: rtl/nsfp_uart_tx.sv */
// Serial transmitter: 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`include "nsfp_params.svh"
module nsfp_uart_tx #(
  parameter int BIT_CYC = `NSFP_BIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Characters in
  nsfp_byte_if.snk bus,
  // Serial line
  output logic txd
);
  import nsfp_pkg::*;

  localparam int CW = $clog2(BIT_CYC);

  logic [8:0] shR, shNxt; // Data bits then stop bit, LSB first
  logic [3:0] bitsR, bitsNxt; // Bits still to send after the current one
  logic [CW-1:0] cntR, cntNxt; // Cycles into the current bit
  logic txdR, txdNxt; // Line level, idle high
  logic busyR, busyNxt; // A character is on the line

  // No flow control input: ready depends only on our own progress
  assign bus.ready = !busyR;
  assign txd = txdR;

  // ----------------------------------------------------------------
  // Bit sequencing
  // ----------------------------------------------------------------
  always_comb begin
    shNxt = shR;
    bitsNxt = bitsR;
    cntNxt = cntR;
    txdNxt = txdR;
    busyNxt = busyR;
    if (!busyR) begin
      // Take a character and open with the start bit
      if (bus.valid) begin
        shNxt = {1'b1, bus.data};
        bitsNxt = 4'h9;
        cntNxt = '0;
        txdNxt = 1'b0;
        busyNxt = 1'b1;
      end
    end else if (cntR == CW'(BIT_CYC - 1)) begin
      cntNxt = '0;
      if (bitsR == 4'h0) begin
        // Stop bit has had its full time
        busyNxt = 1'b0;
      end else begin
        txdNxt = shR[0];
        shNxt = {1'b1, shR[8:1]};
        bitsNxt = bitsR - 4'h1;
      end
    end else begin
      cntNxt = cntR + CW'(1);
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      shR <= '1;
      bitsR <= 4'h0;
      cntR <= '0;
      txdR <= 1'b1;
      busyR <= 1'b0;
    end else begin
      shR <= shNxt;
      bitsR <= bitsNxt;
      cntR <= cntNxt;
      txdR <= txdNxt;
      busyR <= busyNxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_start_bit;
    !busyR && bus.valid |=> !txdR && busyR && cntR == '0;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missing");

  property p_bit_time;
    $changed(txdR) |-> $past(cntR) == CW'(BIT_CYC - 1) || !$past(busyR);
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("line changed inside a bit");

endmodule // nsfp_uart_tx
